// >>> src/switch_port_debug_regs_pkg.sv
package switch_port_debug_regs_pkg;

  localparam int NUM_PORTS = 3;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_OPERATION_MODE       = 12'h098;
  localparam logic [ADDR_W-1:0] OFF_PORT_LINK_HOLD       = 12'h324;
  localparam logic [ADDR_W-1:0] OFF_LED_CONFIG_0         = 12'h328;
  localparam logic [ADDR_W-1:0] OFF_LED_CONFIG_1         = 12'h32C;
  localparam logic [ADDR_W-1:0] OFF_LINK_STATE_SNAPSHOT  = 12'h33C;
  localparam logic [ADDR_W-1:0] OFF_MAC_OPTION_STATUS    = 12'h340;
  localparam logic [ADDR_W-1:0] OFF_TL_TUNING            = 12'h344;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_PROBE_CONTROL  = 12'h348;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_PROBE_DATA     = 12'h34C;

  // Implemented bits; everything else is reserved
  localparam logic [DATA_W-1:0] MASK_OPERATION_MODE      = 32'h00FF_0000;
  localparam logic [DATA_W-1:0] MASK_PORT_LINK_HOLD      = 32'h0007_0707;
  localparam logic [DATA_W-1:0] MASK_LED_CONFIG_0        = 32'h0000_01FF;
  localparam logic [DATA_W-1:0] MASK_LED_CONFIG_1        = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] MASK_LINK_STATE_SNAPSHOT = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] MASK_MAC_OPTION_STATUS   = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] MASK_TL_TUNING           = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] MASK_DEBUG_PROBE_CONTROL = 32'h0000_01FF;

  // Reset values
  localparam logic [DATA_W-1:0] RST_OPERATION_MODE       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_PORT_LINK_HOLD       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_LED_CONFIG_0         = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_LED_CONFIG_1         = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_LINK_STATE_SNAPSHOT  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MAC_OPTION_STATUS    = 32'h0000_0004;
  localparam logic [DATA_W-1:0] RST_TL_TUNING            = 32'h0000_0003;
  localparam logic [DATA_W-1:0] RST_DEBUG_PROBE_CONTROL  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_DEBUG_PROBE_DATA     = 32'h0000_0000;

  // Field positions
  localparam int HOLD_LSB               = 0;
  localparam int QUIET_LSB              = 8;
  localparam int PATTERN_RATE_LSB       = 16;
  localparam int MAC_ADAPTIVE_ACK_BIT   = 4;
  localparam int MAC_FIX_DIS_DETECT_BIT = 5;
  localparam int DBG_MODE_LSB           = 0;
  localparam int DBG_MODE_W             = 5;
  localparam int DBG_PORT_LSB           = 5;
  localparam int DBG_PORT_W             = 3;
  localparam int DBG_START_BIT          = 8;
  localparam int CLKBUF_CTRL_LSB        = 16;
  localparam int CLKBUF_CTRL_W          = 8;

  localparam logic [DBG_MODE_W-1:0] DBG_MODE_LTSSM = 5'h00;
  localparam int DBG_NUM_GROUPS_DEFAULT = 4;

  // Clock figures
  localparam int REFCLK_FREQ_MHZ   = 100;
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int STRAP_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    STRAP_SYNC   = 3'b001,
    STRAP_SAMPLE = 3'b010,
    STRAP_RUN    = 3'b100
  } strap_state_type;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        byte_en;
    logic [DATA_W-1:0] wdata;
  } cfg_req_type;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } cfg_rsp_type;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eeprom_load_type;

  function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old_word,
                                                   input logic [DATA_W-1:0] new_word,
                                                   input logic [3:0]        byte_en,
                                                   input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] lanes;
    lanes = '0;
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = {8{byte_en[i]}};
    end
    return (old_word & ~(lanes & mask)) | (new_word & lanes & mask);
  endfunction : merge_word

endpackage : switch_port_debug_regs_pkg

// >>> src/debug_probe_capture.sv
module debug_probe_capture #(
  parameter int NUM_GROUPS = 4,
  parameter int NUM_PORTS  = 3
) (
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 reset_in,
  input  wire logic                                 start_in,
  input  wire logic [4:0]                           mode_in,
  input  wire logic [2:0]                           port_in,
  input  wire logic [NUM_GROUPS*NUM_PORTS*32-1:0]   probe_in,
  output logic      [31:0]                          data_out
);
  import switch_port_debug_regs_pkg::*;

  logic [31:0] probe_words [NUM_GROUPS*NUM_PORTS];
  logic [31:0] data_q;
  logic [31:0] data_d;
  logic [31:0] selected_word;
  logic        group_valid;
  logic        port_valid;
  int unsigned word_index;

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS*NUM_PORTS; g++) begin : g_unpack
      assign probe_words[g] = probe_in[g*32 +: 32];
    end
  endgenerate

  // Group 0 is the LTSSM group; unknown groups or ports capture zero
  assign group_valid   = (32'(mode_in) < NUM_GROUPS);
  assign port_valid    = (32'(port_in) < NUM_PORTS);
  assign word_index    = 32'(mode_in) * NUM_PORTS + 32'(port_in);
  assign selected_word = (group_valid && port_valid) ? probe_words[word_index] : 32'h0000_0000;
  // Capture runs while start is set, so the word freezes when software clears it
  assign data_d        = start_in ? selected_word : data_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      data_q <= RST_DEBUG_PROBE_DATA;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_out = data_q;

endmodule : debug_probe_capture

// >>> src/switch_port_debug_regs.sv
module switch_port_debug_regs #(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int NUM_GROUPS  = switch_port_debug_regs_pkg::DBG_NUM_GROUPS_DEFAULT
) (
  input  wire logic                                        clk_sys_in,
  input  wire logic                                        reset_in,
  input  switch_port_debug_regs_pkg::cfg_req_type          cfg_req_in,
  output switch_port_debug_regs_pkg::cfg_rsp_type          cfg_rsp_out,
  input  switch_port_debug_regs_pkg::eeprom_load_type      eeprom_load_in,
  input  wire logic                                        clock_buffer_powerdown_strap_in,
  input  wire logic [NUM_GROUPS*switch_port_debug_regs_pkg::NUM_PORTS*32-1:0] probe_in,
  output logic [switch_port_debug_regs_pkg::NUM_PORTS-1:0] ltssm_hold_quiet_out,
  output logic [switch_port_debug_regs_pkg::NUM_PORTS-1:0] pattern_rate_out,
  output logic [8:0]                                       led_config_0_out,
  output logic [31:0]                                      led_config_1_out,
  output logic                                             adaptive_ack_enable_out,
  output logic                                             fix_disable_detect_out,
  output logic [7:0]                                       tl_tuning_out,
  output logic                                             clock_buffer_enable_out,
  output logic [switch_port_debug_regs_pkg::NUM_PORTS-1:0] reference_clock_out_pairs_en_out
);
  import switch_port_debug_regs_pkg::*;

  // Register storage
  logic [DATA_W-1:0] operation_mode_q;
  logic [DATA_W-1:0] operation_mode_d;
  logic [DATA_W-1:0] port_link_hold_q;
  logic [DATA_W-1:0] port_link_hold_d;
  logic [DATA_W-1:0] led_config_0_q;
  logic [DATA_W-1:0] led_config_0_d;
  logic [DATA_W-1:0] led_config_1_q;
  logic [DATA_W-1:0] led_config_1_d;
  logic [DATA_W-1:0] link_state_snapshot_q;
  logic [DATA_W-1:0] link_state_snapshot_d;
  logic [DATA_W-1:0] mac_option_status_q;
  logic [DATA_W-1:0] mac_option_status_d;
  logic [DATA_W-1:0] tl_tuning_q;
  logic [DATA_W-1:0] tl_tuning_d;
  logic [DATA_W-1:0] debug_control_q;
  logic [DATA_W-1:0] debug_control_d;
  logic [DATA_W-1:0] debug_data;

  // Access decode
  logic              cfg_wr;
  logic              cfg_rd;
  logic              hit_opmode;
  logic              hit_hold;
  logic              hit_led0;
  logic              hit_led1;
  logic              hit_snapshot;
  logic              hit_mac;
  logic              hit_tl;
  logic              hit_dbg_ctrl;
  logic              hit_dbg_data;
  logic              ee_opmode;
  logic              ee_hold;
  logic              ee_led0;
  logic              ee_led1;
  logic              ee_snapshot;
  logic              ee_mac;
  logic              ee_tl;
  logic              ee_dbg_ctrl;
  logic [DATA_W-1:0] rdata_d;
  cfg_rsp_type       rsp_q;
  cfg_rsp_type       rsp_d;

  // Strap capture
  logic              strap_meta_q;
  logic              strap_sync_q;
  logic              powerdown_q;
  logic              powerdown_d;
  strap_state_type   strap_state_q;
  strap_state_type   strap_state_d;
  logic [1:0]        sync_count_q;
  logic [1:0]        sync_count_d;

  // Registered outputs
  logic [NUM_PORTS-1:0] hold_d;
  logic [NUM_PORTS-1:0] hold_q;
  logic [NUM_PORTS-1:0] rate_q;
  logic [8:0]           led0_q;
  logic [31:0]          led1_q;
  logic                 ack_pol_q;
  logic                 dis_detect_q;
  logic [7:0]           tl_q;
  logic                 buf_en_d;
  logic                 buf_en_q;
  logic [NUM_PORTS-1:0] pair_en_d;
  logic [NUM_PORTS-1:0] pair_en_q;

  assign cfg_wr = cfg_req_in.valid && cfg_req_in.write;
  assign cfg_rd = cfg_req_in.valid && !cfg_req_in.write;

  assign hit_opmode   = (cfg_req_in.addr == OFF_OPERATION_MODE);
  assign hit_hold     = (cfg_req_in.addr == OFF_PORT_LINK_HOLD);
  assign hit_led0     = (cfg_req_in.addr == OFF_LED_CONFIG_0);
  assign hit_led1     = (cfg_req_in.addr == OFF_LED_CONFIG_1);
  assign hit_snapshot = (cfg_req_in.addr == OFF_LINK_STATE_SNAPSHOT);
  assign hit_mac      = (cfg_req_in.addr == OFF_MAC_OPTION_STATUS);
  assign hit_tl       = (cfg_req_in.addr == OFF_TL_TUNING);
  // Downstream ports have no debug probe space; those offsets act unmapped
  assign hit_dbg_ctrl = IS_UPSTREAM && (cfg_req_in.addr == OFF_DEBUG_PROBE_CONTROL);
  assign hit_dbg_data = IS_UPSTREAM && (cfg_req_in.addr == OFF_DEBUG_PROBE_DATA);

  assign ee_opmode   = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_OPERATION_MODE);
  assign ee_hold     = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_PORT_LINK_HOLD);
  assign ee_led0     = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_LED_CONFIG_0);
  assign ee_led1     = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_LED_CONFIG_1);
  assign ee_snapshot = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_LINK_STATE_SNAPSHOT);
  assign ee_mac      = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_MAC_OPTION_STATUS);
  assign ee_tl       = eeprom_load_in.valid && (eeprom_load_in.addr == OFF_TL_TUNING);
  assign ee_dbg_ctrl = IS_UPSTREAM && eeprom_load_in.valid
                       && (eeprom_load_in.addr == OFF_DEBUG_PROBE_CONTROL);

  // Software writes beat a startup load landing in the same cycle
  assign operation_mode_d =
    (cfg_wr && hit_opmode) ? merge_word(operation_mode_q, cfg_req_in.wdata,
                                        cfg_req_in.byte_en, MASK_OPERATION_MODE) :
    ee_opmode ? (eeprom_load_in.data & MASK_OPERATION_MODE) : operation_mode_q;

  assign port_link_hold_d =
    (cfg_wr && hit_hold) ? merge_word(port_link_hold_q, cfg_req_in.wdata,
                                      cfg_req_in.byte_en, MASK_PORT_LINK_HOLD) :
    ee_hold ? (eeprom_load_in.data & MASK_PORT_LINK_HOLD) : port_link_hold_q;

  assign led_config_0_d =
    (cfg_wr && hit_led0) ? merge_word(led_config_0_q, cfg_req_in.wdata,
                                      cfg_req_in.byte_en, MASK_LED_CONFIG_0) :
    ee_led0 ? (eeprom_load_in.data & MASK_LED_CONFIG_0) : led_config_0_q;

  assign led_config_1_d =
    (cfg_wr && hit_led1) ? merge_word(led_config_1_q, cfg_req_in.wdata,
                                      cfg_req_in.byte_en, MASK_LED_CONFIG_1) :
    ee_led1 ? (eeprom_load_in.data & MASK_LED_CONFIG_1) : led_config_1_q;

  // Snapshot and MAC option status are read-only to software; only the startup load may change them
  assign link_state_snapshot_d =
    ee_snapshot ? (eeprom_load_in.data & MASK_LINK_STATE_SNAPSHOT)
                : link_state_snapshot_q;

  assign mac_option_status_d =
    ee_mac ? (eeprom_load_in.data & MASK_MAC_OPTION_STATUS) : mac_option_status_q;

  assign tl_tuning_d =
    (cfg_wr && hit_tl) ? merge_word(tl_tuning_q, cfg_req_in.wdata,
                                    cfg_req_in.byte_en, MASK_TL_TUNING) :
    ee_tl ? (eeprom_load_in.data & MASK_TL_TUNING) : tl_tuning_q;

  assign debug_control_d =
    (cfg_wr && hit_dbg_ctrl) ? merge_word(debug_control_q, cfg_req_in.wdata,
                                          cfg_req_in.byte_en,
                                          MASK_DEBUG_PROBE_CONTROL) :
    ee_dbg_ctrl ? (eeprom_load_in.data & MASK_DEBUG_PROBE_CONTROL) : debug_control_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      operation_mode_q      <= RST_OPERATION_MODE;
      port_link_hold_q      <= RST_PORT_LINK_HOLD;
      led_config_0_q        <= RST_LED_CONFIG_0;
      led_config_1_q        <= RST_LED_CONFIG_1;
      link_state_snapshot_q <= RST_LINK_STATE_SNAPSHOT;
      mac_option_status_q   <= RST_MAC_OPTION_STATUS;
      tl_tuning_q           <= RST_TL_TUNING;
      debug_control_q       <= RST_DEBUG_PROBE_CONTROL;
    end else begin
      operation_mode_q      <= operation_mode_d;
      port_link_hold_q      <= port_link_hold_d;
      led_config_0_q        <= led_config_0_d;
      led_config_1_q        <= led_config_1_d;
      link_state_snapshot_q <= link_state_snapshot_d;
      mac_option_status_q   <= mac_option_status_d;
      tl_tuning_q           <= tl_tuning_d;
      debug_control_q       <= debug_control_d;
    end
  end

  debug_probe_capture #(
    .NUM_GROUPS (NUM_GROUPS),
    .NUM_PORTS  (NUM_PORTS)
  ) u_probe (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .start_in   (IS_UPSTREAM && debug_control_q[DBG_START_BIT]),
    .mode_in    (debug_control_q[DBG_MODE_LSB +: DBG_MODE_W]),
    .port_in    (debug_control_q[DBG_PORT_LSB +: DBG_PORT_W]),
    .probe_in   (probe_in),
    .data_out   (debug_data)
  );

  // Read data; unmapped offsets and reserved bits return zero
  assign rdata_d =
    hit_opmode   ? (operation_mode_q & MASK_OPERATION_MODE) :
    hit_hold     ? (port_link_hold_q & MASK_PORT_LINK_HOLD) :
    hit_led0     ? (led_config_0_q & MASK_LED_CONFIG_0) :
    hit_led1     ? (led_config_1_q & MASK_LED_CONFIG_1) :
    hit_snapshot ? (link_state_snapshot_q & MASK_LINK_STATE_SNAPSHOT) :
    hit_mac      ? (mac_option_status_q & MASK_MAC_OPTION_STATUS) :
    hit_tl       ? (tl_tuning_q & MASK_TL_TUNING) :
    hit_dbg_ctrl ? (debug_control_q & MASK_DEBUG_PROBE_CONTROL) :
    hit_dbg_data ? debug_data :
                   32'h0000_0000;

  assign rsp_d.ack   = cfg_req_in.valid;
  assign rsp_d.rdata = cfg_rd ? rdata_d : 32'h0000_0000;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign cfg_rsp_out = rsp_q;

  // Strap pin: two-stage synchroniser, then a single sample after reset release
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      strap_meta_q <= 1'b1;
      strap_sync_q <= 1'b1;
    end else begin
      strap_meta_q <= clock_buffer_powerdown_strap_in;
      strap_sync_q <= strap_meta_q;
    end
  end

  always_comb begin
    strap_state_d = strap_state_q;
    sync_count_d  = sync_count_q;
    powerdown_d   = powerdown_q;
    case (strap_state_q)
      STRAP_SYNC: begin
        // Wait until the synchroniser holds a post-reset pin level
        sync_count_d = sync_count_q + 2'd1;
        if (sync_count_q == 2'(STRAP_SYNC_STAGES - 1)) begin
          strap_state_d = STRAP_SAMPLE;
        end
      end
      STRAP_SAMPLE: begin
        powerdown_d   = strap_sync_q;
        strap_state_d = STRAP_RUN;
      end
      STRAP_RUN: begin
        strap_state_d = STRAP_RUN;
      end
      default: begin
        strap_state_d = STRAP_SYNC;
        sync_count_d  = 2'd0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      strap_state_q <= STRAP_SYNC;
      sync_count_q  <= 2'd0;
      powerdown_q   <= 1'b1;
    end else begin
      strap_state_q <= strap_state_d;
      sync_count_q  <= sync_count_d;
      powerdown_q   <= powerdown_d;
    end
  end

  // Buffer stays off until the strap is known, so no glitchy clock leaves the part
  assign buf_en_d = (strap_state_q == STRAP_RUN) && !powerdown_q;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      assign hold_d[p]    = port_link_hold_q[HOLD_LSB + p]
                            | port_link_hold_q[QUIET_LSB + p];
      assign pair_en_d[p] = buf_en_d && !operation_mode_q[CLKBUF_CTRL_LSB + p];
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      hold_q       <= '0;
      rate_q       <= '0;
      led0_q       <= '0;
      led1_q       <= '0;
      ack_pol_q    <= 1'b0;
      dis_detect_q <= 1'b0;
      tl_q         <= '0;
      buf_en_q     <= 1'b0;
      pair_en_q    <= '0;
    end else begin
      hold_q       <= hold_d;
      rate_q       <= port_link_hold_q[PATTERN_RATE_LSB +: NUM_PORTS];
      led0_q       <= led_config_0_q[8:0];
      led1_q       <= led_config_1_q;
      ack_pol_q    <= mac_option_status_q[MAC_ADAPTIVE_ACK_BIT];
      dis_detect_q <= mac_option_status_q[MAC_FIX_DIS_DETECT_BIT];
      tl_q         <= tl_tuning_q[7:0];
      buf_en_q     <= buf_en_d;
      pair_en_q    <= pair_en_d;
    end
  end

  assign ltssm_hold_quiet_out             = hold_q;
  assign pattern_rate_out                 = rate_q;
  assign led_config_0_out                 = led0_q;
  assign led_config_1_out                 = led1_q;
  assign adaptive_ack_enable_out          = ack_pol_q;
  assign fix_disable_detect_out           = dis_detect_q;
  assign tl_tuning_out                    = tl_q;
  assign clock_buffer_enable_out          = buf_en_q;
  assign reference_clock_out_pairs_en_out = pair_en_q;

endmodule : switch_port_debug_regs

// >>> tb/cfg_host_model.sv
module cfg_host_model (
  input  wire logic                               clk_sys_in,
  input  switch_port_debug_regs_pkg::cfg_req_type cmd_in,
  output switch_port_debug_regs_pkg::cfg_req_type cfg_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import switch_port_debug_regs_pkg::*;
  // Launched just after an edge so each request is steady for a full cycle
  always_ff @(posedge clk_sys_in) cfg_req_out <= cmd_in;
endmodule : cfg_host_model

// >>> tb/switch_port_debug_regs_chk.sv
module switch_port_debug_regs_chk (
  input  wire logic                                   clk_sys_in,
  input  wire logic                                   reset_in,
  input  switch_port_debug_regs_pkg::cfg_req_type     cfg_req_in,
  input  switch_port_debug_regs_pkg::cfg_rsp_type     cfg_rsp_out,
  input  switch_port_debug_regs_pkg::eeprom_load_type eeprom_load_in,
  input  logic [2:0]                                  ltssm_hold_quiet_out,
  input  logic                                        adaptive_ack_enable_out,
  input  logic                                        fix_disable_detect_out,
  input  logic                                        clock_buffer_enable_out,
  input  logic [2:0]                                  reference_clock_out_pairs_en_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import switch_port_debug_regs_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire rd_req = cfg_req_in.valid && !cfg_req_in.write;
  wire wr_full = cfg_req_in.valid && cfg_req_in.write && cfg_req_in.byte_en == 4'hF;
  chk_hold_reserved_zero: assert property (
    rd_req && cfg_req_in.addr == OFF_PORT_LINK_HOLD |=>
    (cfg_rsp_out.rdata & ~MASK_PORT_LINK_HOLD) == '0) else $error("hold reserved bits set");
  chk_ctrl_reserved_zero: assert property (
    rd_req && cfg_req_in.addr == OFF_DEBUG_PROBE_CONTROL |=> cfg_rsp_out.rdata[31:9] == '0)
    else $error("debug control reserved bits set");
  chk_snapshot_width: assert property (
    rd_req && cfg_req_in.addr == OFF_LINK_STATE_SNAPSHOT |=> cfg_rsp_out.rdata[31:8] == '0)
    else $error("snapshot upper bits set");
  chk_mac_width: assert property (
    rd_req && cfg_req_in.addr == OFF_MAC_OPTION_STATUS |=> cfg_rsp_out.rdata[31:16] == '0)
    else $error("mac option upper bits set");
  chk_hold_follows_write: assert property (
    wr_full && cfg_req_in.addr == OFF_PORT_LINK_HOLD |-> ##2 ltssm_hold_quiet_out ==
    ($past(cfg_req_in.wdata[2:0], 2) | $past(cfg_req_in.wdata[10:8], 2)))
    else $error("hold output does not follow write");
  chk_mac_load_outputs: assert property (
    eeprom_load_in.valid && eeprom_load_in.addr == OFF_MAC_OPTION_STATUS |-> ##2
    {adaptive_ack_enable_out, fix_disable_detect_out} ==
    {$past(eeprom_load_in.data[4], 2), $past(eeprom_load_in.data[5], 2)})
    else $error("mac option outputs wrong after load");
  chk_buffer_gates_pairs: assert property (
    !clock_buffer_enable_out [*2] |-> reference_clock_out_pairs_en_out == '0)
    else $error("pairs enabled while buffer off");
  chk_pair_disable_bits: assert property (
    wr_full && cfg_req_in.addr == OFF_OPERATION_MODE && clock_buffer_enable_out |-> ##2
    reference_clock_out_pairs_en_out == ~$past(cfg_req_in.wdata[18:16], 2))
    else $error("pair enables do not follow control bits");
  cover property (eeprom_load_in.valid);
  cover property (wr_full && cfg_req_in.addr == OFF_DEBUG_PROBE_CONTROL && cfg_req_in.wdata[8]);
  cover property (clock_buffer_enable_out && reference_clock_out_pairs_en_out != 3'h7);
endmodule : switch_port_debug_regs_chk
bind switch_port_debug_regs switch_port_debug_regs_chk i_switch_port_debug_regs_chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .cfg_req_in(cfg_req_in),
  .cfg_rsp_out(cfg_rsp_out), .eeprom_load_in(eeprom_load_in),
  .ltssm_hold_quiet_out(ltssm_hold_quiet_out), .adaptive_ack_enable_out(adaptive_ack_enable_out),
  .fix_disable_detect_out(fix_disable_detect_out),
  .clock_buffer_enable_out(clock_buffer_enable_out),
  .reference_clock_out_pairs_en_out(reference_clock_out_pairs_en_out));

// >>> tb/test_switch_port_debug_regs.sv
module test_switch_port_debug_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import switch_port_debug_regs_pkg::*;
  logic            clk_sys_in = 1'b0;
  logic            reset_in = 1'b1;
  logic            strap = 1'b0;
  cfg_req_type     cmd = '0;
  cfg_req_type     cfg_req;
  cfg_rsp_type     cfg_rsp;
  eeprom_load_type eld = '0;
  logic [383:0]    probe = '0;
  logic [2:0]      hold, pairs, rate;
  logic [8:0]      led0;
  logic [31:0]     led1;
  logic [7:0]      tl;
  logic            aack, fdd, cben;
  cfg_rsp_type     dn_rsp;
  logic [31:0]     expq[$];
  logic [31:0]     dnq[$];
  int              mismatches = 0;
  int              check_count = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  cfg_host_model i_cfg_host_model (.clk_sys_in(clk_sys_in), .cmd_in(cmd), .cfg_req_out(cfg_req));
  switch_port_debug_regs i_switch_port_debug_regs (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp), .eeprom_load_in(eld),
    .clock_buffer_powerdown_strap_in(strap), .probe_in(probe), .ltssm_hold_quiet_out(hold),
    .pattern_rate_out(rate), .led_config_0_out(led0), .led_config_1_out(led1),
    .adaptive_ack_enable_out(aack), .fix_disable_detect_out(fdd), .tl_tuning_out(tl),
    .clock_buffer_enable_out(cben), .reference_clock_out_pairs_en_out(pairs));
  // Downstream copy sees the same traffic but must hide the probe registers
  switch_port_debug_regs #(.IS_UPSTREAM(1'b0)) i_switch_port_debug_regs_dn (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .cfg_req_in(cfg_req), .cfg_rsp_out(dn_rsp),
    .eeprom_load_in(eld), .clock_buffer_powerdown_strap_in(strap), .probe_in(probe),
    .ltssm_hold_quiet_out(), .pattern_rate_out(), .led_config_0_out(), .led_config_1_out(),
    .adaptive_ack_enable_out(), .fix_disable_detect_out(), .tl_tuning_out(),
    .clock_buffer_enable_out(), .reference_clock_out_pairs_en_out());
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [31:0] e);
    @(posedge clk_sys_in);
    cmd <= '{valid: 1'b1, write: w, addr: a, byte_en: be, wdata: d};
    expq.push_back(e);
    dnq.push_back((a == OFF_DEBUG_PROBE_CONTROL || a == OFF_DEBUG_PROBE_DATA) ? 32'h0000_0000 : e);
  endtask : acc
  task automatic idle(input int n);
    @(posedge clk_sys_in);
    cmd <= '0;
    repeat (n) @(posedge clk_sys_in);
    // Level outputs are looked at away from the launching edge
    @(negedge clk_sys_in);
  endtask : idle
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Every acknowledge consumes the oldest note; writes answer with zero
  always @(negedge clk_sys_in) begin
    if (cfg_rsp.ack === 1'b1) begin
      if (expq.size() == 0) cmp(cfg_rsp.rdata, 32'hDEAD_BEEF);
      else cmp(cfg_rsp.rdata, expq.pop_front());
    end
    if (dn_rsp.ack === 1'b1) begin
      if (dnq.size() == 0) cmp(dn_rsp.rdata, 32'hDEAD_BEEF);
      else cmp(dn_rsp.rdata, dnq.pop_front());
    end
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    logic [31:0] d;
    int m, p;
    void'($urandom(15));
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 12; i++) probe[i*32 +: 32] <= $urandom;
    acc(0, OFF_PORT_LINK_HOLD, 0, 4'hF, 0);
    acc(0, OFF_LINK_STATE_SNAPSHOT, 0, 4'hF, 0);
    acc(0, OFF_MAC_OPTION_STATUS, 0, 4'hF, 32'h4);
    acc(0, OFF_TL_TUNING, 0, 4'hF, 32'h3);
    acc(0, OFF_DEBUG_PROBE_CONTROL, 0, 4'hF, 0);
    acc(1, OFF_MAC_OPTION_STATUS, 32'hFFFF, 4'hF, 0);
    acc(0, OFF_MAC_OPTION_STATUS, 0, 4'hF, 32'h4);
    acc(1, 12'h350, '1, 4'hF, 0);
    acc(0, 12'h350, 0, 4'hF, 0);
    repeat (8) begin
      d = $urandom;
      acc(1, OFF_PORT_LINK_HOLD, d, 4'hF, 0);
      acc(0, OFF_PORT_LINK_HOLD, 0, 4'hF, d & MASK_PORT_LINK_HOLD);
    end
    acc(1, OFF_PORT_LINK_HOLD, 32'h0005_0403, 4'hF, 0);
    acc(1, OFF_PORT_LINK_HOLD, 0, 4'h1, 0);
    acc(0, OFF_PORT_LINK_HOLD, 0, 4'hF, 32'h0005_0400);
    idle(2);
    cmp(32'(hold), 32'h4);
    cmp(32'(rate), 32'h5);
    @(posedge clk_sys_in);
    eld <= '{valid: 1'b1, addr: OFF_MAC_OPTION_STATUS, data: 32'h30};
    @(posedge clk_sys_in);
    eld <= '{valid: 1'b1, addr: OFF_LINK_STATE_SNAPSHOT, data: 32'h1AB};
    @(posedge clk_sys_in);
    eld <= '0;
    acc(0, OFF_MAC_OPTION_STATUS, 0, 4'hF, 32'h30);
    acc(0, OFF_LINK_STATE_SNAPSHOT, 0, 4'hF, 32'hAB);
    acc(1, OFF_LED_CONFIG_0, 32'hFFFF_FFFF, 4'hF, 0);
    acc(0, OFF_LED_CONFIG_0, 0, 4'hF, 32'h0000_01FF);
    acc(1, OFF_LED_CONFIG_1, 32'hA5C3_0F96, 4'hF, 0);
    acc(1, OFF_TL_TUNING, 32'h1234_5678, 4'hF, 0);
    acc(0, OFF_TL_TUNING, 0, 4'hF, 32'h0000_0078);
    acc(1, OFF_OPERATION_MODE, 32'hFF02_0000, 4'hF, 0);
    acc(0, OFF_OPERATION_MODE, 0, 4'hF, 32'h0002_0000);
    idle(2);
    cmp({30'h0, aack, fdd}, 32'h3);
    cmp(32'({cben, pairs}), 32'hD);
    cmp(32'({led0, tl}), 32'h0001_FF78);
    cmp(led1, 32'hA5C3_0F96);
    // Start then stop at once; the single capture taken between must stay frozen
    for (int k = 0; k < 3; k++) begin
      m = (k == 2) ? 5 : k;
      p = 2 - k;
      acc(1, OFF_DEBUG_PROBE_CONTROL, 32'h100 | (p << 5) | m, 4'hF, 0);
      acc(1, OFF_DEBUG_PROBE_CONTROL, (p << 5) | m, 4'hF, 0);
      acc(0, OFF_DEBUG_PROBE_DATA, 0, 4'hF, m < 4 ? probe[(m*3+p)*32 +: 32] : 0);
    end
    idle(3);
    cmp(expq.size() + dnq.size(), 0);
    results();
  end
endmodule : test_switch_port_debug_regs
